// ==== hw/cbd_device.sv ====
// Device end: link intake, byte assembly and stream expansion
`timescale 1ns/1ns
module cbd_device
   import cbd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   cbd_link_if.device link,
   input wire logic [3:0] mode_select_inputs_in, // Strap pins
   input wire logic jtag_config_in, // Boundary scan loading overrides straps
   input wire logic compress_en_in, // This device's image is compressed
   input wire logic local_update_in, // Requests local rather than remote update
   output logic [7:0] cell_data_out, // Expanded byte for the cells
   output logic cell_valid_out, // One cycle per expanded byte
   output logic expand_on_out, // Expansion in use
   output logic remote_update_out, // Remote update selected
   output logic mode_error_out // Unsupported scheme or update request
);
   // ********************************************************
   // Input synchronisers
   // ********************************************************
   logic [16:0] sync1_q, sync1_d; // First stage, read only by the second
   logic [16:0] sync2_q, sync2_d; // Second stage
   logic clk_prev_q, clk_prev_d; // Link clock one cycle ago
   logic lclk; // Synchronised link clock
   logic act; // Synchronised frame flag
   logic [7:0] ldat; // Synchronised data
   logic [3:0] ms_s; // Synchronised straps
   logic jtag_s, comp_s, lu_s; // Synchronised level pins
   logic rise;
   assign lclk = sync2_q[0];
   assign act = sync2_q[1];
   assign ldat = sync2_q[9:2];
   assign ms_s = sync2_q[13:10];
   assign {lu_s, comp_s, jtag_s} = sync2_q[16:14];
   assign rise = lclk & ~clk_prev_q & act;
   // Sync next values
   always_comb begin
      sync1_d = {local_update_in, compress_en_in, jtag_config_in, mode_select_inputs_in,
                 link.data, link.frame_active, link.config_clock};
      sync2_d = sync1_q;
      clk_prev_d = lclk;
   end
   // Sync registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         clk_prev_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         clk_prev_q <= clk_prev_d;
      end
   end
   // ********************************************************
   // Scheme selection, latched outside a frame
   // ********************************************************
   cbd_scheme_t sch_q, sch_d;
   logic [3:0] ms_q, ms_d; // Latched pattern
   logic jtag_q, jtag_d;
   logic exp_en; // Expansion allowed and requested
   always_comb begin
      sch_d = sch_q;
      ms_d = ms_q;
      jtag_d = jtag_q;
      if (!act) begin
         ms_d = ms_s;
         jtag_d = jtag_s;
         sch_d = jtag_s ? CBD_SCH_NONE : cbd_decode(ms_s);
      end
   end
   // Expansion only in the three schemes, never plain or async parallel
   assign exp_en = comp_s & ~jtag_q &
                   (sch_q == CBD_SCH_FPPX || sch_q == CBD_SCH_PS
                    || sch_q == CBD_SCH_AS);
   // Scheme registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sch_q <= CBD_SCH_NONE;
         ms_q <= 4'h0;
         jtag_q <= 1'b0;
      end else begin
         sch_q <= sch_d;
         ms_q <= ms_d;
         jtag_q <= jtag_d;
      end
   end
   // ********************************************************
   // Active serial clock divider
   // ********************************************************
   logic [3:0] div_q, div_d; // Half period counter
   logic config_clock_q, config_clock_d; // Driven link clock
   logic [3:0] half; // Half period length
   always_comb begin
      half = (ms_q == MS_AS_SLOW || ms_q == MS_AS_SLOW_RU) ?
             4'(AS_SLOW_HALF) : 4'(AS_FAST_HALF);
      div_d = div_q;
      config_clock_d = config_clock_q;
      if (sch_q != CBD_SCH_AS || !act) begin
         div_d = 4'h0;
         config_clock_d = 1'b0;
      end else if (div_q + HALF_W1 >= half) begin
         div_d = 4'h0;
         config_clock_d = ~config_clock_q;
      end else begin
         div_d = div_q + HALF_W1;
      end
   end
   // Divider registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         div_q <= 4'h0;
         config_clock_q <= 1'b0;
      end else begin
         div_q <= div_d;
         config_clock_q <= config_clock_d;
      end
   end
   assign link.clk_dev_o = config_clock_q;
   assign link.clk_dev_oe = (sch_q == CBD_SCH_AS);
   // ********************************************************
   // Byte assembly
   // ********************************************************
   logic [1:0] phase_q, phase_d; // Edge count within a slow word
   logic [2:0] bit_q, bit_d; // Serial bit count
   logic [7:0] shift_q, shift_d; // Serial shifter, first bit lowest
   logic [7:0] byte_q, byte_d; // Assembled byte
   logic byte_vld_q, byte_vld_d; // One cycle pulse
   always_comb begin
      phase_d = phase_q;
      bit_d = bit_q;
      shift_d = shift_q;
      byte_d = byte_q;
      byte_vld_d = 1'b0;
      if (!act) begin
         // Counters restart so capture aligns to the first edge
         phase_d = PHASE_CAPTURE;
         bit_d = 3'h0;
      end else if (rise) begin
         case (sch_q)
            CBD_SCH_FPP, CBD_SCH_PPA: begin
               byte_d = ldat;
               byte_vld_d = 1'b1;
            end
            CBD_SCH_FPPX: begin
               // Word held four clocks, take it on the first
               phase_d = phase_q + 2'h1;
               if (phase_q == PHASE_CAPTURE) begin
                  byte_d = ldat;
                  byte_vld_d = 1'b1;
               end
            end
            CBD_SCH_PS, CBD_SCH_AS: begin
               shift_d = {ldat[0], shift_q[7:1]};
               bit_d = bit_q + 3'h1;
               if (bit_q == BIT_LAST) begin
                  byte_d = {ldat[0], shift_q[7:1]};
                  byte_vld_d = 1'b1;
               end
            end
            default: byte_vld_d = 1'b0;
         endcase
      end
   end
   // Assembly registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         phase_q <= PHASE_CAPTURE;
         bit_q <= 3'h0;
         shift_q <= 8'h00;
         byte_q <= 8'h00;
         byte_vld_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         bit_q <= bit_d;
         shift_q <= shift_d;
         byte_q <= byte_d;
         byte_vld_q <= byte_vld_d;
      end
   end
   // ********************************************************
   // Expander: zero runs of at most sixteen bytes take at most
   // sixteen cycles, far less than one slow word or serial byte
   // ********************************************************
   cbd_exp_t exp_q, exp_d;
   logic [4:0] run_q, run_d; // Zero bytes left in the run
   logic [7:0] cell_q, cell_d;
   logic cell_vld_q, cell_vld_d;
   logic err_q, err_d;
   always_comb begin
      exp_d = exp_q;
      run_d = run_q;
      cell_d = cell_q;
      cell_vld_d = 1'b0;
      err_d = err_q;
      case (exp_q)
         CBD_EXP_IDLE: begin
            if (byte_vld_q) begin
               if (!exp_en) begin
                  cell_d = byte_q;
                  cell_vld_d = 1'b1;
               end else if (byte_q[7:4] == TOK_RUN_HI) begin
                  run_d = {1'b0, byte_q[3:0]};
                  cell_d = ZERO_BYTE;
                  cell_vld_d = 1'b1;
                  exp_d = (byte_q[3:0] == 4'h0) ? CBD_EXP_IDLE : CBD_EXP_RUN;
               end else if (byte_q == TOK_ESC) begin
                  exp_d = CBD_EXP_LIT;
               end else begin
                  cell_d = byte_q;
                  cell_vld_d = 1'b1;
               end
            end
         end
         CBD_EXP_RUN: begin
            // One zero byte a cycle, done before the next byte
            cell_d = ZERO_BYTE;
            cell_vld_d = 1'b1;
            run_d = run_q - RUN_ONE;
            if (run_q == RUN_ONE) begin
               exp_d = CBD_EXP_IDLE;
            end
         end
         CBD_EXP_LIT: begin
            if (byte_vld_q) begin
               cell_d = byte_q;
               cell_vld_d = 1'b1;
               exp_d = CBD_EXP_IDLE;
            end
         end
         default: exp_d = CBD_EXP_IDLE;
      endcase
      if (!act) begin
         exp_d = CBD_EXP_IDLE;
         run_d = 5'h00;
      end
      // Error: no scheme, or local update asked in active serial
      err_d = act & ((sch_q == CBD_SCH_NONE && !jtag_q)
                     || (sch_q == CBD_SCH_AS && lu_s));
   end
   // Expander registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         exp_q <= CBD_EXP_IDLE;
         run_q <= 5'h00;
         cell_q <= 8'h00;
         cell_vld_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         exp_q <= exp_d;
         run_q <= run_d;
         cell_q <= cell_d;
         cell_vld_q <= cell_vld_d;
         err_q <= err_d;
      end
   end
   assign cell_data_out = cell_q;
   assign cell_valid_out = cell_vld_q;
   assign expand_on_out = exp_en;
   assign remote_update_out = (sch_q == CBD_SCH_AS) | ~lu_s;
   assign mode_error_out = err_q;
endmodule : cbd_device

// ==== hw/cbd_host.sv ====
// Host end: feeds configuration bytes over the link
`timescale 1ns/1ns
module cbd_host
   import cbd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   cbd_link_if.host link,
   input wire logic [3:0] mode_in, // Same pattern as the device straps
   input wire logic enable_in, // Frame: high for a whole configuration
   input wire logic [7:0] word_in, // Byte to send, prepared once only
   input wire logic word_valid_in,
   output logic word_ready_out // Byte taken this cycle
);
   // ********************************************************
   // Synchroniser for a device made clock
   // ********************************************************
   logic s1_q, s1_d; // First stage, read only by the second
   logic s2_q, s2_d;
   logic sp_q, sp_d; // Previous synchronised level
   logic dev_fall;
   assign dev_fall = ~s2_q & sp_q;
   always_comb begin
      s1_d = link.config_clock;
      s2_d = s1_q;
      sp_d = s2_q;
   end
   // Sync registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         sp_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         sp_q <= sp_d;
      end
   end
   // ********************************************************
   // Sender
   // ********************************************************
   cbd_scheme_t sch;
   logic busy_q, busy_d; // A byte is on the link
   logic clk_q, clk_d; // Made link clock
   logic [3:0] div_q, div_d; // Half period count
   logic [3:0] per_q, per_d; // Clock periods spent on this byte
   logic [7:0] dat_q, dat_d; // Data pins
   logic [3:0] pace;
   logic take;
   assign sch = cbd_decode(mode_in);
   // Whole chain shares this pacing, so one setting for all devices
   assign pace = (sch == CBD_SCH_FPPX) ? PACE_SLOW :
                 ((sch == CBD_SCH_FPP || sch == CBD_SCH_PPA) ? PACE_FAST : PACE_SERIAL);
   always_comb begin
      busy_d = busy_q;
      clk_d = clk_q;
      div_d = div_q;
      per_d = per_q;
      dat_d = dat_q;
      take = 1'b0;
      if (!enable_in) begin
         busy_d = 1'b0;
         clk_d = 1'b0;
         div_d = 4'h0;
      end else if (!busy_q) begin
         // Load a byte; the clock is low and still
         if (word_valid_in) begin
            take = 1'b1;
            busy_d = 1'b1;
            dat_d = word_in;
            per_d = 4'h0;
            div_d = 4'h0;
         end
      end else if (sch == CBD_SCH_AS) begin
         // Follow the device clock, shift on its falling edge
         if (dev_fall) begin
            per_d = per_q + 4'h1;
            dat_d = {1'b0, dat_q[7:1]};
            if (per_q + 4'h1 == PACE_SERIAL) begin
               busy_d = 1'b0;
               if (word_valid_in) begin
                  take = 1'b1;
                  busy_d = 1'b1;
                  dat_d = word_in;
                  per_d = 4'h0;
               end
            end
         end
      end else if (div_q + HALF_W1 >= 4'(HOST_HALF)) begin
         div_d = 4'h0;
         clk_d = ~clk_q;
         if (clk_q) begin
            // Falling edge: next bit or next byte
            per_d = per_q + 4'h1;
            if (sch == CBD_SCH_PS) begin
               dat_d = {1'b0, dat_q[7:1]};
            end
            if (per_q + 4'h1 == pace) begin
               busy_d = 1'b0;
               if (word_valid_in) begin
                  take = 1'b1;
                  busy_d = 1'b1;
                  dat_d = word_in;
                  per_d = 4'h0;
               end
            end
         end
      end else begin
         div_d = div_q + HALF_W1;
      end
   end
   // Sender registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         busy_q <= 1'b0;
         clk_q <= 1'b0;
         div_q <= 4'h0;
         per_q <= 4'h0;
         dat_q <= 8'h00;
      end else begin
         busy_q <= busy_d;
         clk_q <= clk_d;
         div_q <= div_d;
         per_q <= per_d;
         dat_q <= dat_d;
      end
   end
   assign word_ready_out = take;
   assign link.data = dat_q;
   assign link.frame_active = enable_in;
   assign link.clk_host_o = clk_q;
   assign link.clk_host_oe = (sch != CBD_SCH_AS);
endmodule : cbd_host

// ==== hw/cbd_link_if.sv ====
// Link between the configuration host and the configurable device
`timescale 1ns/1ns
interface cbd_link_if;
   logic clk_host_o; // Link clock driven by host
   logic clk_host_oe;
   logic clk_dev_o; // Link clock driven by device in active serial
   logic clk_dev_oe;
   logic config_clock; // Resolved link clock
   logic [7:0] data; // Parallel word, bit 0 is serial data
   logic frame_active; // Host holds high for a whole configuration
   assign config_clock = clk_dev_oe ? clk_dev_o : (clk_host_oe ? clk_host_o : 1'b0);
   modport device (input config_clock, input data, input frame_active,
                   output clk_dev_o, output clk_dev_oe);
   modport host (input config_clock, output data, output frame_active,
                 output clk_host_o, output clk_host_oe);
endinterface : cbd_link_if

// ==== hw/cbd_pkg.sv ====
// Shared constants and types for the configuration intake link
package cbd_pkg;
   // ********************************************************
   // Clock and timing
   // ********************************************************
   localparam int CLK_NS = 4; // Core clock period
   localparam int AS_SLOW_NS = 50; // Active serial clock, 20 MHz
   localparam int AS_FAST_NS = 25; // Active serial clock, 40 MHz
   localparam int HOST_CLK_NS = 32; // Host made link clock period
   // Half periods in core cycles, a least time rounds up
   localparam int AS_SLOW_HALF = (AS_SLOW_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
   localparam int AS_FAST_HALF = (AS_FAST_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
   localparam int HOST_HALF = (HOST_CLK_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
   localparam logic [3:0] HALF_W1 = 4'h1; // One core cycle
   // ********************************************************
   // Link pacing
   // ********************************************************
   localparam logic [3:0] PACE_FAST = 4'h1; // Clocks per word, plain parallel
   localparam logic [3:0] PACE_SLOW = 4'h4; // Clocks per word, expanding parallel
   localparam logic [3:0] PACE_SERIAL = 4'h8; // Clocks per byte, serial
   // ********************************************************
   // Mode select patterns
   // ********************************************************
   localparam logic [3:0] MS_FPP = 4'h0;
   localparam logic [3:0] MS_PPA = 4'h1;
   localparam logic [3:0] MS_PS = 4'h2;
   localparam logic [3:0] MS_AS_FAST = 4'h8;
   localparam logic [3:0] MS_AS_FAST_RU = 4'h9;
   localparam logic [3:0] MS_FPP_X = 4'hB;
   localparam logic [3:0] MS_AS_SLOW = 4'hD;
   localparam logic [3:0] MS_AS_SLOW_RU = 4'hE;
   // ********************************************************
   // Compressed stream tokens
   // ********************************************************
   localparam logic [3:0] TOK_RUN_HI = 4'h8; // 1000_nnnn: nnnn+1 zero bytes
   localparam logic [7:0] TOK_ESC = 8'h90; // Next byte is a literal
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [4:0] RUN_ONE = 5'h01;
   localparam logic [1:0] PHASE_CAPTURE = 2'h0; // Capture phase of four
   localparam logic [2:0] BIT_LAST = 3'h7;
   // ********************************************************
   // Types
   // ********************************************************
   typedef enum logic [2:0] {
      CBD_SCH_NONE = 3'b000,
      CBD_SCH_FPP = 3'b001,
      CBD_SCH_FPPX = 3'b010,
      CBD_SCH_PPA = 3'b011,
      CBD_SCH_PS = 3'b100,
      CBD_SCH_AS = 3'b101
   } cbd_scheme_t;
   typedef enum logic [1:0] {
      CBD_EXP_IDLE = 2'b00,
      CBD_EXP_RUN = 2'b01,
      CBD_EXP_LIT = 2'b10
   } cbd_exp_t;
   // Scheme from the mode select pattern
   function automatic cbd_scheme_t cbd_decode(input logic [3:0] ms);
      if (ms == MS_FPP) begin
         return CBD_SCH_FPP;
      end else if (ms == MS_FPP_X) begin
         return CBD_SCH_FPPX;
      end else if (ms == MS_PPA) begin
         return CBD_SCH_PPA;
      end else if (ms == MS_PS) begin
         return CBD_SCH_PS;
      end else if (ms == MS_AS_FAST || ms == MS_AS_FAST_RU || ms == MS_AS_SLOW
                   || ms == MS_AS_SLOW_RU) begin
         return CBD_SCH_AS;
      end else begin
         return CBD_SCH_NONE;
      end
   endfunction : cbd_decode
endpackage : cbd_pkg

// ==== verification/cbd_link_asserts.sv ====
// Concurrent checks on the link between the host and device ends
`timescale 1ns/1ns
module cbd_link_asserts
   import cbd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] mode_in,
   input wire logic clk_host_o,
   input wire logic clk_dev_o,
   input wire logic clk_dev_oe,
   input wire logic config_clock,
   input wire logic [7:0] data,
   input wire logic frame_active
);
   // ****************
   // Helper counters
   // ****************
   logic [3:0] rise_q; // Link rises since the word changed
   logic [3:0] rise_d;
   logic [3:0] quiet_q; // Cycles with the frame low
   logic [3:0] quiet_d;
   logic [7:0] data_q; // Word of the cycle before
   logic [7:0] data_d;
   logic seen_q; // Link clock of the cycle before
   logic seen_d;
   // Next values of the counters
   always_comb begin
      data_d = data;
      seen_d = config_clock;
      rise_d = rise_q;
      quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
      if (frame_active) begin // Count only outside frames
         quiet_d = 4'h0;
      end
      if (!frame_active || data != data_q) begin // New word restarts the count
         rise_d = 4'h0;
      end else if (config_clock && !seen_q) begin // Rising link edge
         rise_d = rise_q + 4'h1;
      end
      if (rst_in) begin // Clear on reset
         rise_d = 4'h0;
         quiet_d = 4'h0;
      end
   end
   // Register the counters
   always_ff @(posedge clk_in) begin
      rise_q <= rise_d;
      quiet_q <= quiet_d;
      data_q <= data_d;
      seen_q <= seen_d;
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   a_clock_rest: assert property (quiet_q == 4'hF |-> !config_clock)
      else $error("link clock moves outside a frame");
   a_data_steady: assert property (frame_active && config_clock && !clk_dev_oe |-> $stable(data))
      else $error("link data changed while the clock was high");
   a_host_high: assert property ($rose(clk_host_o) |-> clk_host_o [*4] ##1 !clk_host_o)
      else $error("host clock high phase wrong");
   a_host_low: assert property ($fell(clk_host_o) && frame_active |-> !clk_host_o [*4])
      else $error("host clock low phase short");
   a_dev_high: assert property ($rose(clk_dev_o) |-> clk_dev_o [*4])
      else $error("device clock high phase short");
   a_dev_low: assert property ($fell(clk_dev_o) && frame_active |-> !clk_dev_o [*4])
      else $error("device clock low phase short");
   a_dev_clock_as: assert property (clk_dev_oe |-> cbd_decode(mode_in) == CBD_SCH_AS)
      else $error("device drives the clock outside active serial");
   a_word_four: assert property (frame_active && $past(frame_active) && mode_in == MS_FPP_X
      && data != $past(data) |-> rise_q[1:0] == 2'h0)
      else $error("expanding parallel word changed off a fourth edge");
endmodule : cbd_link_asserts

// ==== verification/testbench.sv ====
// Self-checking bench joining the host and device ends
`timescale 1ns/1ns
module testbench
   import cbd_pkg::*;
;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] mode_in = MS_PS; // Host mode
   logic [3:0] ms_in = MS_PS; // Device straps
   logic enable_in = 1'b0;
   logic word_valid_in = 1'b0;
   logic [7:0] word_in = 8'h00;
   logic jtag_in = 1'b0;
   logic comp_in = 1'b0;
   logic local_in = 1'b0;
   logic word_ready_out;
   logic [7:0] cell_data_out;
   logic cell_valid_out, expand_on_out, remote_update_out, mode_error_out;
   int errors = 0;
   int checks = 0;
   int seed = 45;
   int cycles = 0;
   logic [7:0] exp_q[$]; // Cells still due
   bit esc, capt, expand_exp, ignore_cells;
   cbd_link_if link();
   cbd_host cbd_host_i(.clk_in(clk_in), .rst_in(rst_in), .link(link), .mode_in(mode_in),
      .enable_in(enable_in), .word_in(word_in), .word_valid_in(word_valid_in),
      .word_ready_out(word_ready_out));
   cbd_device cbd_device_i(.clk_in(clk_in), .rst_in(rst_in), .link(link),
      .mode_select_inputs_in(ms_in), .jtag_config_in(jtag_in), .compress_en_in(comp_in),
      .local_update_in(local_in), .cell_data_out(cell_data_out),
      .cell_valid_out(cell_valid_out), .expand_on_out(expand_on_out),
      .remote_update_out(remote_update_out), .mode_error_out(mode_error_out));
   cbd_link_asserts cbd_link_asserts_i(.clk_in(clk_in), .rst_in(rst_in), .mode_in(mode_in),
      .clk_host_o(link.clk_host_o), .clk_dev_o(link.clk_dev_o), .clk_dev_oe(link.clk_dev_oe),
      .config_clock(link.config_clock), .data(link.data), .frame_active(link.frame_active));
   // Core clock
   initial begin
      forever #2 clk_in = ~clk_in;
   end
   // Verdict and end of run
   task automatic close_out();
      if (errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   // Compare one value
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      checks++;
      if (got !== want) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask : check
   // Expected cells for one sent byte
   function automatic void model(input logic [7:0] b);
      if (!expand_exp || esc) begin // Plain or escaped literal
         exp_q.push_back(b);
         esc = 1'b0;
      end else if (b == TOK_ESC) begin
         esc = 1'b1;
      end else if (b[7:4] == TOK_RUN_HI) begin // Run of zero bytes
         for (int i = 0; i <= int'(b[3:0]); i++) begin
            exp_q.push_back(ZERO_BYTE);
         end
      end else begin
         exp_q.push_back(b);
      end
   endfunction : model
   // Hand one byte to the host, held until taken
   task automatic send(input logic [7:0] b);
      int n;
      word_in <= b;
      word_valid_in <= 1'b1;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (word_ready_out !== 1'b1 && n < 400);
      @(posedge clk_in);
      if (n >= 400) begin // Byte never taken
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, word_ready_out, 1'b1);
      end
      if (capt) begin
         model(b);
      end
   endtask : send
   // One frame of eight bytes with given mode settings
   task automatic frame(input logic [3:0] hm, input logic [3:0] dm, input logic c,
                        input logic j);
      logic [7:0] bs [8];
      int r, n;
      @(posedge clk_in);
      enable_in <= 1'b0;
      mode_in <= hm;
      ms_in <= dm;
      comp_in <= c;
      jtag_in <= j;
      repeat (10) @(posedge clk_in);
      ignore_cells = 1'b0;
      esc = 1'b0;
      capt = !j && dm != 4'h3;
      expand_exp = c && !j && (dm == MS_FPP_X || dm == MS_PS);
      bs = '{8'h82, TOK_ESC, 8'h85, 8'h8F, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 4; i < 8; i++) begin // Random tail
         r = $random(seed);
         bs[i] = r[7:0];
      end
      enable_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      check({7'h00, expand_on_out}, {7'h00, expand_exp});
      if (!j) begin
         check({7'h00, mode_error_out}, {7'h00, dm == 4'h3});
      end
      foreach (bs[i]) send(bs[i]);
      word_valid_in <= 1'b0;
      n = 0;
      while (exp_q.size() != 0 && n < 2000) begin // Bounded drain
         @(posedge clk_in);
         n++;
      end
      repeat (80) @(posedge clk_in);
      check(8'(exp_q.size()), 8'h00);
   endtask : frame
   // Active serial frame without words
   task automatic as_run(input logic [3:0] m, input logic lu);
      @(posedge clk_in);
      enable_in <= 1'b0;
      mode_in <= m;
      ms_in <= m;
      local_in <= lu;
      comp_in <= 1'b1;
      jtag_in <= 1'b0;
      ignore_cells = 1'b1;
      repeat (10) @(posedge clk_in);
      enable_in <= 1'b1;
      repeat (120) @(posedge clk_in);
      check({7'h00, remote_update_out}, 8'h01);
      check({7'h00, mode_error_out}, {7'h00, lu});
      check({7'h00, expand_on_out}, 8'h01);
      @(negedge link.clk_dev_o); // Cut the frame just after a falling link edge
      @(posedge clk_in);
      enable_in <= 1'b0;
      local_in <= 1'b0;
      repeat (30) @(posedge clk_in);
   endtask : as_run
   // Cell monitor and timeout
   always @(posedge clk_in) begin
      cycles++;
      if (cycles > 20000) begin // Hang
         errors++;
         close_out();
      end
      if (!rst_in && cell_valid_out === 1'b1 && !ignore_cells) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, cell_valid_out, 1'b0);
         end else begin
            check(cell_data_out, exp_q.pop_front());
         end
      end
   end
   // Main sequence
   initial begin
      logic [3:0] asm [4];
      asm = '{MS_AS_FAST, MS_AS_FAST_RU, MS_AS_SLOW, MS_AS_SLOW_RU};
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      frame(MS_PS, MS_PS, 1'b1, 1'b0);
      frame(MS_PS, MS_PS, 1'b0, 1'b0);
      frame(MS_FPP_X, MS_FPP_X, 1'b1, 1'b0);
      frame(MS_FPP_X, MS_FPP_X, 1'b0, 1'b0);
      frame(MS_FPP, MS_FPP, 1'b1, 1'b0);
      frame(MS_PPA, MS_PPA, 1'b1, 1'b0);
      frame(MS_PS, MS_PS, 1'b1, 1'b1);
      frame(MS_PS, 4'h3, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         as_run(asm[i], i[0]);
      end
      close_out();
   end
endmodule : testbench
